// [rtl/cfa_flags_acc.sv]
// status flags register and accumulator of the core
// assumes the datapath presents alu results and flag ops on clk_in
//
// Behaviour
// [RL1] flags change only via logical flag ops, carry and zero also via alu results
// [RL2] bit 4 selects register bank
// [RL3] bit 3 read-only supervisor indicator
// [RL4] bit 2 carry from each alu op
// [RL5] bit 1 set when result is zero
// [RL6] bit 0 gates all interrupts
// [RL7] accumulator takes each source-mode result
// [RL8] accumulator visible on acc_out, resets zero
// [RL9] reset clears global interrupt enable
// [RL10] bits 7..5 read zero, ignore writes
`timescale 1ns/1ps
module cfa_flags_acc
    import cfa_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic supervisor_in,
    input wire cfa_alu_type alu_in,
    input wire cfa_fop_type fop_in,
    input wire logic [7:0] fop_imm_in,
    input wire logic irq_pending_in,
    output logic [7:0] flags_out,
    output logic [7:0] acc_out,
    output logic bank_select_bit_out,
    output logic global_interrupt_gate_out,
    output logic irq_take_out
);
    // reserved bits, no storage and no live source
    localparam logic [7:0] RSVD_MASK =
        ~(CFA_FLAGS_RW_MASK | (8'h01 << CFA_BIT_SUPER));
    // bits that an alu result owns over a flag op
    localparam logic [7:0] ALU_MASK =
        (8'h01 << CFA_BIT_CARRY) | (8'h01 << CFA_BIT_ZERO);

    // flags group
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [7:0] stored;
    logic [7:0] opv;
    logic zero_hit;

    // accumulator group
    logic [7:0] acc_q;
    logic [7:0] acc_d;
    logic acc_load;

    assign zero_hit = ~|alu_in.result; // [RL5]
    assign acc_load = alu_in.valid & alu_in.to_acc; // [RL7]

    // flag op first, a same-cycle alu result then owns carry and zero
    always_comb
    begin
        stored = flags_q & CFA_FLAGS_RW_MASK;
        opv = stored;
        case (fop_in)
            CFA_FOP_NONE: opv = stored;
            CFA_FOP_AND: opv = stored & fop_imm_in; // [RL1]
            CFA_FOP_OR: opv = stored | fop_imm_in; // [RL1]
            CFA_FOP_XOR: opv = stored ^ fop_imm_in; // [RL1]
            default: opv = stored;
        endcase
        flags_d = opv & CFA_FLAGS_RW_MASK; // [RL10] [RL3]
        if (alu_in.valid)
        begin
            flags_d[CFA_BIT_CARRY] = alu_in.carry; // [RL4]
            flags_d[CFA_BIT_ZERO] = zero_hit; // [RL5]
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            flags_q <= CFA_FLAGS_RESET; // [RL9]
        end
        else
        begin
            flags_q <= flags_d;
        end
    end

    a_zero_flag: assert property ( // [RL5]
        @(posedge clk_in) disable iff (rst_in)
        alu_in.valid |=> flags_out[CFA_BIT_ZERO]
            == ($past(alu_in.result) == 8'h00))
        else $error("zero flag wrong");
    a_carry_flag: assert property ( // [RL4]
        @(posedge clk_in) disable iff (rst_in)
        alu_in.valid |=> flags_out[CFA_BIT_CARRY] == $past(alu_in.carry))
        else $error("carry flag wrong");
    a_flags_hold: assert property ( // [RL1]
        @(posedge clk_in) disable iff (rst_in)
        !alu_in.valid && fop_in == CFA_FOP_NONE |=> $stable(flags_q))
        else $error("flags changed without op");
    a_fop_and: assert property ( // [RL1]
        @(posedge clk_in) disable iff (rst_in)
        !alu_in.valid && fop_in == CFA_FOP_AND |=> flags_q
            == ($past(flags_q) & $past(fop_imm_in) & CFA_FLAGS_RW_MASK))
        else $error("and flag op wrong");
    a_fop_or: assert property ( // [RL1]
        @(posedge clk_in) disable iff (rst_in)
        !alu_in.valid && fop_in == CFA_FOP_OR |=> flags_q
            == (($past(flags_q) | $past(fop_imm_in)) & CFA_FLAGS_RW_MASK))
        else $error("or flag op wrong");
    a_fop_xor: assert property ( // [RL1]
        @(posedge clk_in) disable iff (rst_in)
        !alu_in.valid && fop_in == CFA_FOP_XOR |=> flags_q
            == (($past(flags_q) ^ $past(fop_imm_in)) & CFA_FLAGS_RW_MASK))
        else $error("xor flag op wrong");
    a_alu_only: assert property ( // [RL1]
        @(posedge clk_in) disable iff (rst_in)
        alu_in.valid && fop_in == CFA_FOP_NONE
            |=> (flags_q & ~ALU_MASK) == ($past(flags_q) & ~ALU_MASK))
        else $error("alu op changed a software flag");
    a_bank_or: assert property ( // [RL2]
        @(posedge clk_in) disable iff (rst_in)
        fop_in == CFA_FOP_OR && fop_imm_in[CFA_BIT_BANK]
            |=> bank_select_bit_out)
        else $error("bank bit not set");
    a_bank_and: assert property ( // [RL2]
        @(posedge clk_in) disable iff (rst_in)
        fop_in == CFA_FOP_AND && !fop_imm_in[CFA_BIT_BANK]
            |=> !bank_select_bit_out)
        else $error("bank bit not cleared");

    // accumulator loads only from an alu result aimed at it
    always_comb
    begin
        acc_d = acc_q;
        if (acc_load)
        begin
            acc_d = alu_in.result; // [RL7]
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            acc_q <= CFA_ACC_RESET; // [RL8]
        end
        else
        begin
            acc_q <= acc_d;
        end
    end

    a_acc_load: assert property ( // [RL7]
        @(posedge clk_in) disable iff (rst_in)
        alu_in.valid && alu_in.to_acc |=> acc_out == $past(alu_in.result))
        else $error("accumulator not loaded");
    a_acc_hold: assert property ( // [RL8]
        @(posedge clk_in) disable iff (rst_in)
        !(alu_in.valid && alu_in.to_acc) |=> $stable(acc_out))
        else $error("accumulator changed without op");
    a_acc_valid_only: assert property ( // [RL7]
        @(posedge clk_in) disable iff (rst_in)
        alu_in.to_acc && !alu_in.valid |=> $stable(acc_out))
        else $error("accumulator loaded without valid");

    // bit 3 is not stored: it mirrors the execution mode live
    always_comb
    begin
        flags_out = flags_q & CFA_FLAGS_RW_MASK; // [RL10]
        flags_out[CFA_BIT_SUPER] = supervisor_in; // [RL3]
    end
    assign acc_out = acc_q;
    assign bank_select_bit_out = flags_q[CFA_BIT_BANK]; // [RL2]
    assign global_interrupt_gate_out = flags_q[CFA_BIT_GIE]; // [RL6]
    assign irq_take_out = irq_pending_in & flags_q[CFA_BIT_GIE]; // [RL6]

    a_reserved_zero: assert property ( // [RL10]
        @(posedge clk_in) disable iff (rst_in)
        (flags_out & RSVD_MASK) == 8'h00)
        else $error("reserved flag bits not zero");
    a_super_ro: assert property ( // [RL3]
        @(posedge clk_in) disable iff (rst_in)
        flags_out[CFA_BIT_SUPER] == supervisor_in)
        else $error("supervisor bit not live");
    a_bank_view: assert property ( // [RL2]
        @(posedge clk_in) disable iff (rst_in)
        bank_select_bit_out == flags_out[CFA_BIT_BANK])
        else $error("bank select output differs from flags");
    a_gate_view: assert property ( // [RL6]
        @(posedge clk_in) disable iff (rst_in)
        global_interrupt_gate_out == flags_out[CFA_BIT_GIE])
        else $error("gate output differs from flags");
    a_irq_gate: assert property ( // [RL6]
        @(posedge clk_in) disable iff (rst_in)
        irq_take_out == (irq_pending_in && global_interrupt_gate_out))
        else $error("interrupt gate wrong");
    a_reset_gie: assert property ( // [RL9]
        @(posedge clk_in)
        $fell(rst_in) |-> !global_interrupt_gate_out
            && flags_q == CFA_FLAGS_RESET && acc_out == CFA_ACC_RESET)
        else $error("reset did not clear state");

    // stored bits settable by software, the others never hold a one
    for (genvar i = 0; i < $bits(flags_q); i++)
    begin : g_bit_check
        if (CFA_FLAGS_RW_MASK[i])
        begin : g_rw
            a_bit_set: assert property ( // [RL1]
                @(posedge clk_in) disable iff (rst_in)
                fop_in == CFA_FOP_OR && fop_imm_in[i]
                    && !(alu_in.valid && ALU_MASK[i]) |=> flags_q[i])
                else $error("flag op did not set a stored bit");
        end
        else
        begin : g_fixed
            a_bit_fixed: assert property ( // [RL10]
                @(posedge clk_in) disable iff (rst_in)
                !flags_q[i])
                else $error("unstored flag bit holds a one");
        end
    end
endmodule : cfa_flags_acc

// [rtl/cfa_pkg.sv]
// package for the status flags and accumulator block
// assumes a single core clock domain, driven by execution datapath
package cfa_pkg;
    localparam int unsigned CFA_DATA_W = 8;
    localparam int unsigned CFA_BIT_GIE = 0;
    localparam int unsigned CFA_BIT_ZERO = 1;
    localparam int unsigned CFA_BIT_CARRY = 2;
    localparam int unsigned CFA_BIT_SUPER = 3;
    localparam int unsigned CFA_BIT_BANK = 4;
    localparam logic [7:0] CFA_FLAGS_RESET = 8'h02;
    localparam logic [7:0] CFA_ACC_RESET = 8'h00;
    localparam logic [7:0] CFA_FLAGS_RW_MASK = 8'h17;

    // logical op on flags: and, or, xor with an 8-bit immediate
    typedef enum logic [3:0] {
        CFA_FOP_NONE = 4'h1,
        CFA_FOP_AND = 4'h2,
        CFA_FOP_OR = 4'h4,
        CFA_FOP_XOR = 4'h8
    } cfa_fop_type;

    typedef struct packed {
        logic valid;
        logic [7:0] result;
        logic carry;
        logic to_acc;
    } cfa_alu_type;
endpackage : cfa_pkg

// [verification/cfa_dp_model.sv]
// datapath model packing alu results for the flags block
// assumes the bench commands one op per core cycle
`timescale 1ns/1ps
module cfa_dp_model
    import cfa_pkg::*;
(
    input wire logic [7:0] res_in,
    input wire logic [2:0] ctl_in,
    output cfa_alu_type alu_out
);
    // struct order: valid, result, carry, acc load
    assign alu_out = {ctl_in[0], res_in, ctl_in[1], ctl_in[2]};
endmodule : cfa_dp_model

// [verification/test_cfa_flags_acc.sv]
// bench for the flags and accumulator block
// assumes 20 MHz core clock and a reference model in integers
`timescale 1ns/1ps
module test_cfa_flags_acc
    import cfa_pkg::*;
;
logic clk_in = 0, rst_in = 1, sup = 0, irq = 0;
logic [7:0] res = 0, imm = 0, fl, acc;
logic [2:0] ctl = 0;
logic bk, gg, tk;
cfa_fop_type fop = CFA_FOP_NONE;
cfa_alu_type alu;
int n_mismatch = 0, comparisons = 0, f = 2, a = 0, t, k;
always #25 clk_in = ~clk_in;
cfa_dp_model cfa_dp_model_i(.res_in(res), .ctl_in(ctl), .alu_out(alu));
cfa_flags_acc cfa_flags_acc_i(.clk_in(clk_in), .rst_in(rst_in),
    .supervisor_in(sup), .alu_in(alu), .fop_in(fop), .fop_imm_in(imm),
    .irq_pending_in(irq), .flags_out(fl), .acc_out(acc),
    .bank_select_bit_out(bk), .global_interrupt_gate_out(gg),
    .irq_take_out(tk));
task cmp(input string nm, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e)
    begin
        n_mismatch++;
        $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
endtask : cmp
task chk;
    cmp("flags", 8'(f) | {4'h0, sup, 3'h0}, fl);
    cmp("acc", 8'(a), acc);
    cmp("bank", {7'h0, f[4]}, {7'h0, bk});
    cmp("gate", {7'h0, f[0]}, {7'h0, gg});
    cmp("take", {7'h0, f[0] & irq}, {7'h0, tk});
endtask : chk
task complete_run;
    $display("checks %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
        $display("DONE - PASS");
    else
        $display("DONE - FAIL");
    $finish;
endtask : complete_run
task step(input cfa_fop_type nf, input logic [7:0] ni,
    input logic [2:0] nc, input logic [7:0] nr);
    @(posedge clk_in);
    #1;
    t = (fop == CFA_FOP_AND) ? f & imm : (fop == CFA_FOP_OR) ? f | imm :
        (fop == CFA_FOP_XOR) ? f ^ imm : f;
    f = t & 8'h17;
    if (ctl[0])
        f = (f & 8'h11) | (ctl[1] << 2) | ((res == 0) << 1);
    if (ctl[0] & ctl[2]) a = res;
    fop = nf;
    imm = ni;
    ctl = nc;
    res = nr;
    {sup, irq} = 2'($urandom);
    #1 chk();
endtask : step
task run_ops(input int n);
    for (k = 0; k < n; k++)
    begin
        step(cfa_fop_type'(4'h1 << ($urandom % 4)), 8'($urandom),
            3'($urandom), ($urandom % 4 == 0) ? 8'h00 : 8'($urandom));
    end
endtask : run_ops
initial
begin
    #100000 n_mismatch++;
    complete_run();
end
initial
begin
    void'($urandom(32'h00ca8511));
    repeat (16) @(posedge clk_in);
    #1 rst_in = 0;
    chk();
    $display("reset test done");
    step(CFA_FOP_OR, 8'h11, 3'h0, 8'h00);
    step(CFA_FOP_NONE, 8'h00, 3'h7, 8'h00);
    step(CFA_FOP_NONE, 8'h00, 3'h0, 8'h00);
    $display("directed walk test done");
    run_ops(300);
    $display("random op test done");
    step(CFA_FOP_OR, 8'h11, 3'h0, 8'h00);
    step(CFA_FOP_NONE, 8'h00, 3'h0, 8'h00);
    @(posedge clk_in);
    #1 rst_in = 1;
    f = 2;
    a = 0;
    #1 chk();
    repeat (2) @(posedge clk_in);
    #1 rst_in = 0;
    chk();
    $display("mid reset test done");
    run_ops(100);
    $display("second op run done");
    complete_run();
end
endmodule : test_cfa_flags_acc
